/* File: dv/scam_axis_model.sv */
// axis feedback model: interpolator setpoint and encoder
`timescale 1ns/1ps
`default_nettype none
module scam_axis_model
	import scam_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// motion command and encoder lag
	input wire logic move,
	input wire logic [VEL_W-1:0] vel,
	input wire logic [POS_W-1:0] lag,
	// feedback
	output var scam_axis_s axis
);
	logic [POS_W-1:0] sp_r;
	// setpoint advances while moving
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) sp_r <= '0;
		else if (move) sp_r <= sp_r + POS_W'(vel);
	end
	// encoder always present, trails by lag
	assign axis = '{sp_r, sp_r - lag, move ? vel : '0, move};
endmodule // scam_axis_model
`default_nettype wire

/* File: dv/scam_axis_tb.sv */
// testbench for the speed-controlled axis mode block
`timescale 1ns/1ps
`default_nettype none
module scam_axis_tb
	import scam_pkg::*;
;
	logic clock, reset_n, opt, req, clr, servo, move, lo, stp, act, terr, strb, avail;
	logic [1:0] dt;
	logic [POS_W-1:0] tol, lag, rpos;
	logic [15:0] scale;
	logic [VEL_W-1:0] vel, dval;
	scam_inhibit_s inh;
	scam_axis_s axis;
	int bad_count = 0, compares = 0, cyc = 0;
	scam_axis DUT(.clock(clock), .reset_n(reset_n), .option_enable(opt), .drive_type(dt), .speed_request(req),
		.error_clear(clr), .servo_enable(servo), .tolerance(tol), .vel_scale(scale), .inhibit(inh), .axis(axis),
		.loop_open(lo), .drive_value(dval), .axis_stop(stp), .speed_active(act), .tol_error(terr),
		.resync_strobe(strb), .resync_pos(rpos), .mode_available(avail));
	scam_axis_model model(.clock(clock), .reset_n(reset_n), .move(move), .vel(vel), .lag(lag), .axis(axis));
	// 125 MHz clock
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// cycle ceiling against hangs
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task tally_and_finish();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// motion start, loop state checked after the answer
	task automatic move_on(logic exp);
		move = 1'b1;
		tick(2);
		check("loop_open", lo, 32'(exp));
		check("speed_active", act, 32'(exp));
	endtask
	// motion end, resync pulse and captured position
	task automatic move_off(logic exp);
		logic [31:0] p;
		move = 1'b0;
		tick(1);
		p = axis.actual_pos;
		check("resync_strobe", strb, 32'(exp));
		if (exp) check("resync_pos", rpos, p);
		check("loop_closed", lo, 0);
		tick(2);
		check("drive_idle", dval, 0);
	endtask
	initial begin
		{reset_n, opt, req, clr, move, dt, inh} = '0;
		{servo, tol, scale, vel, lag} = {1'b1, TOL_RESET, 16'h0180, 24'h000400, 32'h40};
		tick(20);
		reset_n = 1'b1;
		req = 1'b1;
		tick(2);
		check("avail_off", avail, 0);
		move_on(0);
		move_off(0);
		$display("test option_off done");
		opt = 1'b1;
		for (int d = 0; d < 4; d++) begin
			dt = 2'(d);
			tick(2);
			check("avail_drive", avail, 32'(d < 2));
			move_on(d < 2);
			move_off(d < 2);
		end
		dt = DRV_FIELDBUS;
		for (int i = 0; i < 5; i++) begin
			inh = 5'(1 << i);
			tick(2);
			check("avail_inhibit", avail, 0);
			move_on(0);
			move_off(0);
		end
		inh = '0;
		$display("test gating done");
		move_on(1);
		check("drive_value", dval, 32'h600);
		req = 1'b0;
		tick(3);
		check("held_open", lo, 1);
		move_off(1);
		move_on(0);
		move_off(0);
		{req, servo} = 2'b10;
		move_on(0);
		move_off(0);
		servo = 1'b1;
		$display("test run done");
		move_on(1);
		lag = 32'h200;
		tick(3);
		check("tol_error", terr, 1);
		check("axis_stop", stp, 1);
		check("loop_fault", lo, 0);
		move_off(1);
		lag = 32'h40;
		check("error_held", terr, 1);
		move_on(0);
		move_off(0);
		clr = 1'b1;
		tick(1);
		clr = 1'b0;
		tick(1);
		check("error_cleared", terr, 0);
		move_on(1);
		move_off(1);
		$display("test fault done");
		tally_and_finish();
	end
endmodule // scam_axis_tb
`default_nettype wire

/* File: inc/scam_pkg.sv */
// package for the speed-controlled axis mode block
`default_nettype none
package scam_pkg;
	localparam int POS_W = 32; // position width
	localparam int VEL_W = 24; // velocity / manipulated value width
	localparam logic [31:0] TOL_RESET = 32'h0000_0100; // default tolerance
	localparam logic [15:0] SCALE_RESET = 16'h0100; // unity gain in 8.8
	localparam int SCALE_FRAC = 8; // fractional bits of scale
	localparam logic [1:0] DRV_ANALOG = 2'h0; // analog setpoint output
	localparam logic [1:0] DRV_FIELDBUS = 2'h1; // fieldbus drive
	localparam logic [1:0] DRV_STEPPER = 2'h2; // stepper output

	// axis mode state
	typedef enum logic [1:0] {
		SCAM_POS_HOLD = 2'b00,
		SCAM_SPEED_RUN = 2'b01,
		SCAM_RESYNC = 2'b10,
		SCAM_FAULT = 2'b11
	} scam_state_e;

	// conditions that forbid speed-controlled mode
	typedef struct packed {
		logic ref_approach;
		logic gantry;
		logic coupled;
		logic handling_trafo;
		logic fixed_stop;
	} scam_inhibit_s;

	// feedback from the axis
	typedef struct packed {
		logic [POS_W-1:0] setpoint_pos;
		logic [POS_W-1:0] actual_pos;
		logic [VEL_W-1:0] cmd_vel;
		logic in_motion;
	} scam_axis_s;
endpackage
`default_nettype wire

/* File: verilog/scam_axis.sv */
// speed-controlled axis mode logic for one servo axis
// What this block does
// - while speed-controlled the setpoint/actual deviation is checked and an excess stops the axis with an error.
// - limits and end positions are only held to within that same tolerance, never tighter.
// - speed control is offered only for analog or fieldbus drives, never for steppers.
// - speed control needs both the axis option enabled and the controller request bit set.
// - from a position-held standstill with servo enable the loop opens at motion start and velocity alone drives.
// - at motion end the loop closes again and the interpolator setpoint is loaded with the reached actual position.
// - speed control is refused during reference approach, gantry, coupling, handling transform and fixed stop.
// - the axis option resets to off so the axis traverses position-controlled.
// - the velocity profile is the interpolator's own, the same in both modes.
// - commanded velocity is turned into a drive value using the configured drive scaling.
// - a request withdrawn mid-motion keeps speed control until standstill.
// - after returning to position control block preparation restarts from the reached actual position.
`timescale 1ns/1ps
`default_nettype none
module scam_axis
	import scam_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// configuration and controller request
	input wire logic option_enable,
	input wire logic [1:0] drive_type,
	input wire logic speed_request,
	input wire logic error_clear,
	input wire logic servo_enable,
	input wire logic [POS_W-1:0] tolerance,
	input wire logic [15:0] vel_scale,
	input wire scam_inhibit_s inhibit,
	// axis feedback from the interpolator and encoder
	input wire scam_axis_s axis,
	// drive side
	output logic loop_open,
	output logic [VEL_W-1:0] drive_value,
	output logic axis_stop,
	// status
	output logic speed_active,
	output logic tol_error,
	output logic resync_strobe,
	output logic [POS_W-1:0] resync_pos,
	output logic mode_available
);

	scam_state_e state_r, state_nxt;
	logic opt_r; // latched option, off at reset
	logic tol_error_r, loop_open_r, stop_r, resync_r, avail_r, active_r;
	logic [POS_W-1:0] resync_pos_r;
	logic [VEL_W-1:0] drive_r;
	logic moving_d_r;

	// signed deviation and its magnitude
	function automatic logic [POS_W-1:0] abs_diff(input logic [POS_W-1:0] a, input logic [POS_W-1:0] b);
		logic [POS_W-1:0] d;
		d = a - b;
		return d[POS_W-1] ? (~d + 1'b1) : d;
	endfunction

	wire logic [POS_W-1:0] deviation = abs_diff(axis.setpoint_pos, axis.actual_pos);
	wire logic drive_ok = (drive_type == DRV_ANALOG) || (drive_type == DRV_FIELDBUS);
	wire logic inhibited = |inhibit;
	wire logic may_run = opt_r && speed_request && drive_ok && !inhibited && !tol_error_r;
	wire logic motion_start = axis.in_motion && !moving_d_r;
	wire logic dev_excess = deviation > tolerance;
	wire logic [VEL_W+15:0] scaled = {{16{axis.cmd_vel[VEL_W-1]}}, axis.cmd_vel} * {{VEL_W{1'b0}}, vel_scale};
	wire logic [VEL_W-1:0] drive_calc = scaled[SCALE_FRAC+VEL_W-1:SCALE_FRAC];

	// state decode shared by the registers and the checks
	wire logic in_hold = (state_r == SCAM_POS_HOLD);
	wire logic in_run = (state_r == SCAM_SPEED_RUN);
	wire logic err_set = in_run && dev_excess;
	wire logic enter_run = (state_nxt == SCAM_SPEED_RUN);
	wire logic enter_fault = (state_nxt == SCAM_FAULT);
	wire logic enter_resync = (state_nxt == SCAM_RESYNC);
	wire logic avail_calc = opt_r && drive_ok && !inhibited;

	// mode sequencing
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SCAM_POS_HOLD: begin
				if (may_run && servo_enable && motion_start) begin
					state_nxt = SCAM_SPEED_RUN;
				end
			end
			SCAM_SPEED_RUN: begin
				if (dev_excess) begin
					state_nxt = SCAM_FAULT;
				end else if (!axis.in_motion) begin
					state_nxt = SCAM_RESYNC;
				end
			end
			SCAM_RESYNC: state_nxt = SCAM_POS_HOLD;
			SCAM_FAULT: begin
				if (!axis.in_motion) begin
					state_nxt = SCAM_RESYNC;
				end
			end
			default: state_nxt = SCAM_POS_HOLD;
		endcase
	end

	// state register and option latch
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= SCAM_POS_HOLD;
			opt_r <= 1'b0;
			moving_d_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			opt_r <= option_enable;
			moving_d_r <= axis.in_motion;
		end
	end

	// sticky tolerance error, set wins over clear
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tol_error_r <= 1'b0;
		end else if (err_set) begin
			tol_error_r <= 1'b1;
		end else if (error_clear) begin
			tol_error_r <= 1'b0;
		end
	end

	// loop state and drive value, both follow the next state
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			loop_open_r <= 1'b0;
			active_r <= 1'b0;
			drive_r <= '0;
		end else begin
			loop_open_r <= enter_run;
			active_r <= enter_run;
			drive_r <= enter_run ? drive_calc : '0;
		end
	end

	// fault stop and resync capture
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			stop_r <= 1'b0;
			resync_r <= 1'b0;
			resync_pos_r <= '0;
		end else begin
			stop_r <= enter_fault;
			resync_r <= enter_resync;
			if (enter_resync) begin
				resync_pos_r <= axis.actual_pos;
			end
		end
	end

	// mode availability seen by the controller
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			avail_r <= 1'b0;
		end else begin
			avail_r <= avail_calc;
		end
	end

	assign loop_open = loop_open_r;
	assign drive_value = drive_r;
	assign axis_stop = stop_r;
	assign speed_active = active_r;
	assign tol_error = tol_error_r;
	assign resync_strobe = resync_r;
	assign resync_pos = resync_pos_r;
	assign mode_available = avail_r;

	// deviation monitor checks
	a_excess_stops: assert property (
		@(posedge clock) disable iff (!reset_n)
		err_set |=> (axis_stop && tol_error))
		else $error("deviation excess did not stop axis");
	a_fault_holds: assert property (
		@(posedge clock) disable iff (!reset_n)
		(state_r == SCAM_FAULT && axis.in_motion) |=> axis_stop)
		else $error("stop released while axis still moving");
	a_fault_closes: assert property (
		@(posedge clock) disable iff (!reset_n)
		axis_stop |-> (!loop_open && !speed_active))
		else $error("loop open while axis stopped");
	a_error_cause: assert property (
		@(posedge clock) disable iff (!reset_n)
		$rose(tol_error) |-> $past(err_set))
		else $error("tolerance error raised without excess");
	a_limit_in_tol: assert property (
		@(posedge clock) disable iff (!reset_n)
		(loop_open && $past(loop_open)) |-> !$past(dev_excess))
		else $error("speed run continued beyond tolerance");

	// drive type, request, inhibit and option gating checks
	a_no_stepper_run: assert property (
		@(posedge clock) disable iff (!reset_n)
		(drive_type == DRV_STEPPER && in_hold) |=> !loop_open)
		else $error("speed mode opened for stepper");
	a_bad_drive_run: assert property (
		@(posedge clock) disable iff (!reset_n)
		(in_hold && !drive_ok) |=> !loop_open)
		else $error("speed mode opened for unsupported drive");
	a_avail_drive: assert property (
		@(posedge clock) disable iff (!reset_n)
		mode_available |-> $past(drive_ok))
		else $error("mode available for unsupported drive");
	a_need_request: assert property (
		@(posedge clock) disable iff (!reset_n)
		(in_hold && !(opt_r && speed_request)) |=> !loop_open)
		else $error("loop opened without option and request");
	a_inhibit_blocks: assert property (
		@(posedge clock) disable iff (!reset_n)
		(in_hold && inhibited) |=> !loop_open)
		else $error("speed mode under inhibit");
	a_avail_inhibit: assert property (
		@(posedge clock) disable iff (!reset_n)
		mode_available |-> !$past(inhibited))
		else $error("mode available under inhibit");
	a_option_off_reset: assert property (
		@(posedge clock) disable iff (!reset_n)
		!opt_r |=> !mode_available)
		else $error("mode available with option off");
	a_avail_option: assert property (
		@(posedge clock) disable iff (!reset_n)
		mode_available |-> $past(opt_r))
		else $error("mode available without option");

	// start, hold and end of a speed-controlled motion
	a_start_opens: assert property (
		@(posedge clock) disable iff (!reset_n)
		(in_hold && may_run && servo_enable && motion_start) |=> loop_open)
		else $error("loop not opened at motion start");
	a_servo_needed: assert property (
		@(posedge clock) disable iff (!reset_n)
		(in_hold && !servo_enable) |=> !loop_open)
		else $error("loop opened without servo enable");
	a_start_needs_edge: assert property (
		@(posedge clock) disable iff (!reset_n)
		(in_hold && !motion_start) |=> !loop_open)
		else $error("loop opened without motion start");
	a_rise_needs_grant: assert property (
		@(posedge clock) disable iff (!reset_n)
		$rose(loop_open) |-> $past(may_run))
		else $error("loop opened without grant");
	a_hold_in_motion: assert property (
		@(posedge clock) disable iff (!reset_n)
		(in_run && axis.in_motion && !dev_excess && !speed_request) |=> loop_open)
		else $error("left speed mode while moving");
	a_end_resyncs: assert property (
		@(posedge clock) disable iff (!reset_n)
		(in_run && !dev_excess && !axis.in_motion) |=>
		(resync_strobe && !loop_open && resync_pos == $past(axis.actual_pos)))
		else $error("no resync at motion end");
	a_fault_resyncs: assert property (
		@(posedge clock) disable iff (!reset_n)
		(state_r == SCAM_FAULT && !axis.in_motion) |=> resync_strobe)
		else $error("no resync after stopped fault");
	a_strobe_single: assert property (
		@(posedge clock) disable iff (!reset_n)
		resync_strobe |=> !resync_strobe)
		else $error("resync strobe longer than one cycle");
	a_resync_pos_held: assert property (
		@(posedge clock) disable iff (!reset_n)
		!resync_strobe |-> $stable(resync_pos))
		else $error("resync position moved without strobe");

	// drive value checks
	a_drive_closed: assert property (
		@(posedge clock) disable iff (!reset_n)
		!loop_open |-> (drive_value == '0))
		else $error("drive value with loop closed");
	a_zero_vel_zero: assert property (
		@(posedge clock) disable iff (!reset_n)
		(in_run && !dev_excess && axis.in_motion && axis.cmd_vel == '0) |=> (drive_value == '0))
		else $error("drive value without commanded velocity");

	// sticky error checks
	a_error_sticky: assert property (
		@(posedge clock) disable iff (!reset_n)
		(tol_error && !error_clear) |=> tol_error)
		else $error("tolerance error dropped early");
	a_error_blocks: assert property (
		@(posedge clock) disable iff (!reset_n)
		(in_hold && tol_error) |=> !loop_open)
		else $error("speed run started with error pending");
	a_clear_works: assert property (
		@(posedge clock) disable iff (!reset_n)
		(error_clear && !err_set) |=> !tol_error)
		else $error("tolerance error not cleared");

	// main scenarios
	c_speed_run: cover property (
		@(posedge clock) disable iff (!reset_n) $rose(loop_open));
	c_resync: cover property (
		@(posedge clock) disable iff (!reset_n) resync_strobe);
	c_fault: cover property (
		@(posedge clock) disable iff (!reset_n) $rose(tol_error));
	c_withdraw: cover property (
		@(posedge clock) disable iff (!reset_n) loop_open && !speed_request);
	c_cleared: cover property (
		@(posedge clock) disable iff (!reset_n) $fell(tol_error));
endmodule // scam_axis
`default_nettype wire
